// ### xor_skip_pkg.sv
// constants, states and opcode decoding for the xor/skip execute block
package xor_skip_pkg;

    // ************************************************************
    // register map (byte addresses, one 32-bit word each)
    // ************************************************************
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_BANK = 8'h08;
    localparam logic [7:0] REG_FLAGS = 8'h0c;
    localparam logic [7:0] REG_STATE = 8'h10;
    localparam logic [7:0] REG_COUNT = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int CTRL_RUN = 0;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 4;
    localparam int FIELD_ACCESS = 8;
    localparam int FIELD_DEST = 9;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // ************************************************************
    // opcodes and instruction-cycle phases
    // ************************************************************
    localparam logic [15:0] TST_MASK = 16'hfe00;
    localparam logic [15:0] TST_CODE = 16'h6600;
    localparam logic [15:0] XLW_MASK = 16'hff00;
    localparam logic [15:0] XLW_CODE = 16'h0a00;
    localparam logic [15:0] XWF_MASK = 16'hfc00;
    localparam logic [15:0] XWF_CODE = 16'h1800;
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_SKIP = 4'b0100,
        ST_SKIP2 = 4'b1000
    } core_state_e;

    function automatic logic is_tst(input logic [15:0] w);
        return (w & TST_MASK) == TST_CODE;
    endfunction

    function automatic logic is_xlw(input logic [15:0] w);
        return (w & XLW_MASK) == XLW_CODE;
    endfunction

    function automatic logic is_xwf(input logic [15:0] w);
        return (w & XWF_MASK) == XWF_CODE;
    endfunction

endpackage

// ### xor_flag_unit.sv
// exclusive-or datapath with negative and zero results
module xor_flag_unit
    import xor_skip_pkg::*;
(
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    output logic [7:0] result,
    output logic neg,
    output logic zero
);
    assign result = acc ^ opnd;
    assign neg = result[7];
    assign zero = (result == 8'h00);
endmodule

// ### xor_skip_core.sv
// execute block for the test-skip and the two exclusive-or instructions
// How it works
// - test-skip opcode is 0110 011, then access bit and 8-bit address
// - zero register: prefetched next instruction is flushed, a nop runs instead
// - test-skip lasts one cycle, two on skip, three over a two-word follower
// - test-skip never touches any status flag
// - access bit 0 picks the access bank; 1 picks the bank select register
// - literal xor, 0000 1010 kkkk kkkk, replaces the accumulator with acc^k
// - the literal is the whole low byte of the instruction word
// - both xors update only negative and zero flags from the result
// - register xor, 0001 10da ffff ffff, xors accumulator and file register
// - destination bit 0 writes the accumulator, 1 writes the file register
// - banked address is bank select register joined to the 8-bit address
module xor_skip_core
    import xor_skip_pkg::*;
#(
    parameter int BANK_W = 4,
    parameter logic [7:0] ACC_SPLIT = 8'h80,
    parameter logic [BANK_W-1:0] ACC_HI_BANK = '1
) (
    input wire logic sys_clk,
    input wire logic rst,
    // instruction from the fetch pipeline
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic next_two_word,
    output logic instr_ready,
    output logic flush_next,
    // data memory
    output logic [BANK_W+7:0] dmem_addr,
    output logic dmem_rd,
    input wire logic [7:0] dmem_rdata,
    output logic dmem_wr,
    output logic [7:0] dmem_wdata,
    // axi4-lite slave
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ************************************************************
    // state
    // ************************************************************
    core_state_e state_q, state_d;
    logic [1:0] phase_q;
    logic [15:0] ins_q;
    logic two_word_q;
    logic [7:0] acc_q;
    logic [7:0] flags_q;
    logic [BANK_W-1:0] bank_q;
    logic run_q;
    logic [7:0] result_q;
    logic res_n_q, res_z_q, tst_zero_q;
    logic flush_q, rd_q, wr_q;
    logic [BANK_W+7:0] addr_q;
    logic [7:0] wdata_q;
    logic [15:0] count_q;

    // ************************************************************
    // decode
    // ************************************************************
    wire accept = instr_ready && instr_valid;
    wire in_exec = (state_q == ST_EXEC);
    wire dec_tst = is_tst(ins_q);
    wire dec_xlw = is_xlw(ins_q);
    wire dec_xwf = is_xwf(ins_q);
    wire q1 = (phase_q == PH_Q1);
    wire q3 = (phase_q == PH_Q3);
    wire q4 = (phase_q == PH_Q4);
    wire banked = ins_q[FIELD_ACCESS];
    wire to_reg = ins_q[FIELD_DEST];
    wire [7:0] faddr = ins_q[7:0];
    // the access bank splits the 8-bit address between bank 0 and the top
    wire [BANK_W-1:0] acc_bank = (faddr < ACC_SPLIT) ? '0 : ACC_HI_BANK;
    wire [BANK_W-1:0] eff_bank = banked ? bank_q : acc_bank;
    wire [BANK_W+7:0] eff_addr = {eff_bank, faddr};
    wire needs_read = dec_tst || dec_xwf;
    // literal xor takes the full low byte, register xor the memory byte
    wire [7:0] opnd = dec_xlw ? ins_q[7:0] : dmem_rdata;
    wire [7:0] xor_res;
    wire xor_n, xor_z;

    xor_flag_unit u_xor (
        .acc(acc_q),
        .opnd(opnd),
        .result(xor_res),
        .neg(xor_n),
        .zero(xor_z)
    );

    wire commit = in_exec && q4;
    wire skip_go = commit && dec_tst && tst_zero_q;
    wire acc_load = commit && (dec_xlw || (dec_xwf && !to_reg));
    wire flag_load = commit && (dec_xlw || dec_xwf);

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0] wbuf_q, rdata_q;
    logic [1:0] bresp_q, rresp_q;
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire aw_ok = aw_have_q || aw_fire;
    wire w_ok = w_have_q || w_fire;
    wire wr_go = aw_ok && w_ok && !bvalid_q;
    wire [AXI_AW-1:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_have_q ? wbuf_q : s_axi_wdata;
    // only byte lane 0 carries register data
    wire wlane = wr_go && s_axi_wstrb[0] | (wr_go && w_have_q);
    wire wr_ctrl = wlane && (wa == REG_CTRL);
    wire wr_acc = wlane && (wa == REG_ACC);
    wire wr_bank = wlane && (wa == REG_BANK);
    wire wr_flags = wlane && (wa == REG_FLAGS);
    wire wa_ok = (wa == REG_CTRL) || (wa == REG_ACC) ||
                 (wa == REG_BANK) || (wa == REG_FLAGS);
    wire [31:0] rd_mux =
        (s_axi_araddr == REG_CTRL) ? {31'h0, run_q} :
        (s_axi_araddr == REG_ACC) ? {24'h0, acc_q} :
        (s_axi_araddr == REG_BANK) ? {{(32-BANK_W){1'b0}}, bank_q} :
        (s_axi_araddr == REG_FLAGS) ? {24'h0, flags_q} :
        (s_axi_araddr == REG_STATE) ? {26'h0, phase_q, state_q} :
        (s_axi_araddr == REG_COUNT) ? {16'h0, count_q} : 32'h0;
    wire ra_ok = (s_axi_araddr <= REG_COUNT) && (s_axi_araddr[1:0] == 2'h0);

    // wstrb is only valid while wvalid; hold lane 0 enable with the data
    logic wstrb0_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wbuf_q <= 32'h0;
            wstrb0_q <= 1'b0;
        end else begin
            if (aw_fire && !wr_go) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire && !wr_go) begin
                w_have_q <= 1'b1;
                wbuf_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wa_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= ra_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ************************************************************
    // software-visible registers; the core's own update wins a clash
    // ************************************************************
    wire wbit0 = w_have_q ? wstrb0_q : s_axi_wstrb[0];
    wire sw_acc = wr_acc && wbit0;
    wire sw_flags = wr_flags && wbit0;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_q <= 1'b0;
            bank_q <= '0;
            acc_q <= ACC_RST;
            flags_q <= FLAGS_RST;
        end else begin
            if (wr_ctrl && wbit0)
                run_q <= wd[CTRL_RUN];
            if (wr_bank && wbit0)
                bank_q <= wd[BANK_W-1:0];
            if (acc_load)
                acc_q <= result_q;
            else if (sw_acc)
                acc_q <= wd[7:0];
            if (flag_load) begin
                flags_q[FLAG_N] <= res_n_q;
                flags_q[FLAG_Z] <= res_z_q;
            end else if (sw_flags) begin
                flags_q <= wd[7:0];
            end
        end
    end

    // ************************************************************
    // instruction-cycle sequencer
    // ************************************************************
    assign instr_ready = (state_q == ST_IDLE) && run_q;
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (accept) state_d = ST_EXEC;
            ST_EXEC: if (q4) state_d = skip_go ? ST_SKIP : ST_IDLE;
            ST_SKIP: if (q4) state_d = two_word_q ? ST_SKIP2 : ST_IDLE;
            ST_SKIP2: if (q4) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            phase_q <= PH_Q1;
            ins_q <= 16'h0;
            two_word_q <= 1'b0;
            count_q <= 16'h0;
        end else begin
            state_q <= state_d;
            phase_q <= (accept || state_q == ST_IDLE) ? PH_Q1 : phase_q + 2'h1;
            if (accept)
                ins_q <= instr_word;
            if (commit)
                two_word_q <= next_two_word;
            if (q4 && state_q != ST_IDLE)
                count_q <= count_q + 16'h1;
        end
    end

    // ************************************************************
    // datapath: q1 decode, q2 read, q3 process, q4 write
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_q <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= 8'h0;
            result_q <= 8'h0;
            res_n_q <= 1'b0;
            res_z_q <= 1'b0;
            tst_zero_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            rd_q <= in_exec && q1 && needs_read;
            wr_q <= in_exec && q3 && dec_xwf && to_reg;
            flush_q <= skip_go;
            if (in_exec && q1)
                addr_q <= eff_addr;
            if (in_exec && q3) begin
                result_q <= xor_res;
                res_n_q <= xor_n;
                res_z_q <= xor_z;
                wdata_q <= xor_res;
                tst_zero_q <= (dmem_rdata == 8'h00);
            end
        end
    end

    assign dmem_addr = addr_q;
    assign dmem_rd = rd_q;
    assign dmem_wr = wr_q;
    assign dmem_wdata = wdata_q;
    assign flush_next = flush_q;

    // ************************************************************
    // checks
    // ************************************************************
    tst_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_exec && q1 && dec_tst |=> dmem_rd ##1 !dmem_rd)
        else $error("test-skip did not read its register");
    skip_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        skip_go |=> flush_next && state_q == ST_SKIP ##1 !flush_next)
        else $error("zero test did not flush the next word");
    skip_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        skip_go && !next_two_word |=> (state_q == ST_SKIP)[*4]
        ##1 state_q == ST_IDLE)
        else $error("single skip length wrong");
    skip_two_a: assert property (@(posedge sys_clk) disable iff (rst)
        skip_go && next_two_word |=> ##4 (state_q == ST_SKIP2)[*4]
        ##1 state_q == ST_IDLE)
        else $error("two-word skip length wrong");
    tst_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
        commit && dec_tst && !sw_flags |=> $stable(flags_q))
        else $error("test-skip changed a flag");
    bank_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_exec && q1 && banked |=>
        dmem_addr == {$past(bank_q), $past(ins_q[7:0])})
        else $error("banked address wrong");
    access_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_exec && q1 && !banked |=> dmem_addr[BANK_W+7:8] ==
        (($past(ins_q[7:0]) < ACC_SPLIT) ? '0 : ACC_HI_BANK))
        else $error("access bank address wrong");
    lit_xor_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_exec && q3 && dec_xlw && !sw_acc |=> ##1
        acc_q == ($past(acc_q, 2) ^ $past(ins_q[7:0], 2)))
        else $error("literal xor result wrong");
    nz_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
        flag_load |=> flags_q[FLAG_Z] == ($past(result_q) == 8'h00) &&
        flags_q[FLAG_N] == $past(result_q[7]) &&
        flags_q[3] == $past(flags_q[3]))
        else $error("xor flags wrong");
    reg_dest_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_exec && q3 && dec_xwf && to_reg |=> dmem_wr &&
        dmem_wdata == $past(acc_q ^ dmem_rdata))
        else $error("register xor write-back wrong");
    one_cycle_a: assert property (@(posedge sys_clk) disable iff (rst)
        accept && is_xwf(instr_word) |=> in_exec[*4] ##1 state_q == ST_IDLE)
        else $error("register xor not one cycle");
endmodule

// ### dmem_model.sv
// data memory partner model for the execute block
module dmem_model (
    input wire logic sys_clk,
    input wire logic [11:0] dmem_addr,
    input wire logic dmem_rd,
    input wire logic dmem_wr,
    input wire logic [7:0] dmem_wdata,
    output logic [7:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4095];
    initial dmem_rdata = 8'h5a;
    // data holds for the one cycle after the strobe only, then toggles
    // so that a late sample cannot pass by luck
    always @(posedge sys_clk) begin
        if (dmem_wr) begin
            mem[dmem_addr] <= dmem_wdata;
        end
        if (dmem_rd) begin
            dmem_rdata <= mem[dmem_addr];
        end else begin
            dmem_rdata <= ~dmem_rdata;
        end
    end
endmodule

// ### test_skip_and_xor_exec_tb.sv
// self-checking bench for the xor and test-skip execute block
module test_skip_and_xor_exec_tb;
    import xor_skip_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, ivalid, two, iready, flush, rd, wr;
    logic [15:0] iword;
    logic [11:0] addr, rd_addr;
    logic [7:0] rdata, wdata, awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] axwdata, axrdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] strb;
    int bad_count, total_checks, cyc, flush_cnt, wr_cnt;

    xor_skip_core u_xor_skip_core (.sys_clk(sys_clk), .rst(rst),
        .instr_valid(ivalid), .instr_word(iword), .next_two_word(two),
        .instr_ready(iready), .flush_next(flush), .dmem_addr(addr),
        .dmem_rd(rd), .dmem_rdata(rdata), .dmem_wr(wr), .dmem_wdata(wdata),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(axwdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(axrdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    dmem_model u_dmem_model (.sys_clk(sys_clk), .dmem_addr(addr),
        .dmem_rd(rd), .dmem_wr(wr), .dmem_wdata(wdata), .dmem_rdata(rdata));

    // ************************************************************
    // checking and bus tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // each channel is judged at the rising edge that moves it, and is
    // only released after that edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        logic done;
        @(posedge sys_clk);
        awaddr <= a;
        axwdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                done = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        if (!done) chk(0, 1);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        logic done;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                done = 1'b1;
                d = axrdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        if (!done) chk(0, 1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a);
        chk(d, e);
        chk(r, RESP_OKAY);
    endtask

    // counts cycles from the accept edge until ready returns
    task automatic issue(input logic [15:0] w, input logic tw);
        logic ok;
        ivalid <= 1'b1;
        iword <= w;
        two <= tw;
        ok = 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(negedge sys_clk);
            ok = iready;
            @(posedge sys_clk);
        end
        ivalid <= 1'b0;
        cyc = 0;
        flush_cnt = 0;
        wr_cnt = 0;
        ok = 1'b0;
        while (cyc < 30 && !ok) begin
            @(negedge sys_clk);
            cyc++;
            flush_cnt += flush;
            wr_cnt += wr;
            if (rd) rd_addr = addr;
            ok = iready;
        end
        @(posedge sys_clk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs();
        rd_chk(REG_ACC, ACC_RST);
        rd_chk(REG_FLAGS, FLAGS_RST);
        rd_chk(REG_STATE, {26'h0, PH_Q1, ST_IDLE});
        // lane 0 disabled: the write is answered but must not land
        strb <= 4'he;
        axi_wr(REG_ACC, 32'h77);
        chk(r, RESP_OKAY);
        strb <= 4'hf;
        rd_chk(REG_ACC, ACC_RST);
        axi_rd(8'h18);
        chk(r, RESP_SLVERR);
        chk(d, 0);
        axi_wr(8'h1c, 32'h1);
        chk(r, RESP_SLVERR);
        axi_wr(REG_CTRL, 32'h1);
        $display("register test done");
    endtask

    task automatic t_xor_literal_into_acc();
        axi_wr(REG_ACC, 32'hb5);
        axi_wr(REG_FLAGS, 32'h0b);
        issue(16'h0aaf, 1'b0);
        chk(cyc, 5);
        rd_chk(REG_ACC, 32'h1a);
        rd_chk(REG_FLAGS, 32'h0b);
        issue(16'h0a1a, 1'b0);
        rd_chk(REG_FLAGS, 32'h0f);
        issue(16'h0a80, 1'b0);
        rd_chk(REG_ACC, 32'h80);
        rd_chk(REG_FLAGS, 32'h1b);
        rd_chk(REG_COUNT, 32'h3);
        $display("literal xor test done");
    endtask

    task automatic t_xor_acc_with_reg();
        axi_wr(REG_BANK, 32'h3);
        axi_wr(REG_ACC, 32'hb5);
        axi_wr(REG_FLAGS, 32'h0);
        u_dmem_model.mem[12'h320] = 8'haf;
        u_dmem_model.mem[12'h020] = 8'h0f;
        u_dmem_model.mem[12'hf90] = 8'hba;
        issue(16'h1b20, 1'b0);
        chk(cyc, 5);
        chk(wr_cnt, 1);
        chk(rd_addr, 12'h320);
        chk(u_dmem_model.mem[12'h320], 8'h1a);
        rd_chk(REG_ACC, 32'hb5);
        issue(16'h1820, 1'b0);
        chk(wr_cnt, 0);
        chk(rd_addr, 12'h020);
        rd_chk(REG_ACC, 32'hba);
        rd_chk(REG_FLAGS, 32'h10);
        issue(16'h1890, 1'b0);
        chk(rd_addr, 12'hf90);
        rd_chk(REG_ACC, 32'h0);
        rd_chk(REG_FLAGS, 32'h04);
        $display("register xor test done");
    endtask

    task automatic t_skip();
        axi_wr(REG_FLAGS, 32'h14);
        u_dmem_model.mem[12'h330] = 8'h00;
        u_dmem_model.mem[12'h040] = 8'h07;
        issue(16'h6730, 1'b0);
        chk(cyc, 9);
        chk(flush_cnt, 1);
        chk(wr_cnt, 0);
        chk(rd_addr, 12'h330);
        issue(16'h6730, 1'b1);
        chk(cyc, 13);
        chk(flush_cnt, 1);
        issue(16'h6640, 1'b1);
        chk(cyc, 5);
        chk(flush_cnt, 0);
        chk(rd_addr, 12'h040);
        rd_chk(REG_FLAGS, 32'h14);
        axi_wr(REG_FLAGS, 32'h0);
        issue(16'h6730, 1'b0);
        rd_chk(REG_FLAGS, 32'h0);
        rd_chk(REG_COUNT, 32'he);
        $display("test skip test done");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        #100us;
        bad_count++;
        report_and_stop();
    end

    initial begin
        {rst, ivalid, two, awvalid, wvalid, bready, arvalid, rready} = 8'hff;
        {ivalid, two, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        iword = 16'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        axwdata = 32'h0;
        strb = 4'hf;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_xor_literal_into_acc();
        t_xor_acc_with_reg();
        t_skip();
        report_and_stop();
    end
endmodule
